// ==== core/sdm_map.vh ====
// constants for the sigma-delta mode and calibration control block
// assumes a 100 MHz sys_clk and one filter word per channel per output
//
// What this block does
// - mode bit 3 picks low or normal power
// - normal power: both channels, 512 kHz modulator
// - low power: current channel only, 128 kHz
// - counter, comparator, accumulator work in low power
// - low power current channel raises wake interrupt
// - single code converts once then returns idle
// - continuous code updates results every settled filter output while the FIFO has room
// - each completion sets ready flag, can interrupt
// - overrange marks conversion result invalid, sets error bit
// - idle keeps converter powered, held in reset
// - path: average, subtract offset, scale, clamp, format
// - chop bit enables averaging of filter outputs
// - coefficients load factory values, software may overwrite
// - calibration result goes to result register and FIFO, not coefficients
// - calibration aborts conversion, ends in idle unless a new mode write overrides it
// - offset calibration lasts one filter settling time
// - codes 4, 5, 6, 7 start the calibrations
// - offset is 24-bit two's complement when subtracted
// - nominal gain 0x5555 scales by 4/3, unity correction is 0x4000
`ifndef SDM_MAP_VH
`define SDM_MAP_VH
`define SDM_MODE_LP_BIT 3
`define SDM_MODE_PD 3'h0
`define SDM_MODE_CONT 3'h1
`define SDM_MODE_SINGLE 3'h2
`define SDM_MODE_IDLE 3'h3
`define SDM_MODE_SELF_OFS 3'h4
`define SDM_MODE_SELF_GAIN 3'h5
`define SDM_MODE_SYS_ZERO 3'h6
`define SDM_MODE_SYS_FULL 3'h7
`define SDM_MODE_RST 4'h3
`define SDM_STA_RDY0 0
`define SDM_STA_THR 2
`define SDM_STA_CNT 3
`define SDM_STA_ERR0 12
`define SDM_RES_INV_BIT 31
`define SDM_GAIN_NOM 16'h5555
`define SDM_GAIN_SHIFT 14
`define SDM_SETTLE_OUTS 3'h3
`define SDM_SYS_HZ 100000000
`define SDM_NP_MOD_HZ 512000
`define SDM_LP_MOD_HZ 128000
`define SDM_NP_HALF (`SDM_SYS_HZ / (2 * `SDM_NP_MOD_HZ))
`define SDM_LP_HALF (`SDM_SYS_HZ / (2 * `SDM_LP_MOD_HZ))
`define SDM_PWRUP_WAIT_US 500
`define SDM_FIFO_DEPTH 8
`endif

// ==== core/sdm_fifo.v ====
// result FIFO with a registered output stage
// assumes DEPTH is a power of two and AW its log2
`timescale 1ns/100ps
module sdm_fifo #(
   parameter W = 33,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire sys_clk,
   input wire rstn,
   input wire in_vld,
   output wire in_rdy,
   input wire [W-1:0] in_data,
   output reg out_vld_q,
   input wire out_rdy,
   output reg [W-1:0] out_data_q
);
   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0] cnt_q;
   wire push = in_vld && in_rdy;
   wire pop = (cnt_q != 0) && (!out_vld_q || out_rdy);

   assign in_rdy = (cnt_q != DEPTH[AW:0]);

   always @(posedge sys_clk) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end

   always @(posedge sys_clk) begin
      if (!rstn) begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         out_vld_q <= 1'b0;
         out_data_q <= {W{1'b0}};
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
            out_data_q <= mem[rp_q];
            out_vld_q <= 1'b1;
         end else if (out_rdy) begin
            out_vld_q <= 1'b0;
         end
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule

// ==== core/sdm_corr.v ====
// correction path for one channel: average, offset, gain, clamp
// assumes raw arrives with vld as one decimation filter word
`timescale 1ns/100ps
`include "sdm_map.vh"
module sdm_corr (
   input wire sys_clk,
   input wire rstn,
   input wire [23:0] raw,
   input wire vld,
   input wire chop,
   input wire [23:0] ofs,
   input wire [15:0] gn,
   input wire unip,
   input wire ovr,
   output wire [31:0] res,
   output wire err,
   output wire [31:0] cal_val
);
   reg signed [23:0] prev_q;
   wire signed [24:0] sum = $signed(raw) + prev_q;
   wire signed [23:0] avg = chop ? sum[24:1] : $signed(raw);
   wire signed [24:0] diff = avg - $signed(ofs);
   wire signed [41:0] prod = diff * $signed({1'b0, gn});
   wire signed [27:0] scl = prod[41:`SDM_GAIN_SHIFT];
   wire clip = (scl[27:23] != {5{scl[23]}});
   wire [23:0] sat = clip ? (scl[27] ? 24'h800000 : 24'h7FFFFF)
                          : scl[23:0];
   wire [23:0] fmt = unip ? {~sat[23], sat[22:0]} : sat;

   assign err = ovr | clip;
   assign res = {err, 7'h00, fmt};
   assign cal_val = {{8{avg[23]}}, avg};

   // chopped pairs average the previous word with the current one
   always @(posedge sys_clk) begin
      if (!rstn) begin
         prev_q <= 24'h000000;
      end else if (vld) begin
         prev_q <= $signed(raw);
      end
   end
endmodule

// ==== core/sdm_ctrl.v ====
// mode, conversion and calibration control for two converter channels
// assumes filter words arrive on sys_clk; software picks each mode, the block itself returns single and calibration runs to idle
`timescale 1ns/100ps
`include "sdm_map.vh"
module sdm_ctrl (
   input wire sys_clk,
   input wire rstn,
   input wire mode_wr,
   input wire [3:0] mode_wdata,
   input wire flt_chop,
   input wire [1:0] ch_on,
   input wire [1:0] unip,
   input wire temp_sel,
   input wire [2:0] coef_of_we,
   input wire [2:0] coef_gn_we,
   input wire [23:0] coef_wdata,
   input wire [71:0] fac_of,
   input wire [47:0] fac_gn,
   input wire [15:0] sta_clr,
   input wire [15:0] irq_mask,
   input wire [23:0] thr,
   input wire [7:0] cnt_lim,
   input wire acc_clr,
   input wire [47:0] flt_data,
   input wire [1:0] flt_vld,
   input wire [1:0] flt_ovr,
   input wire res_rdy,
   output reg [3:0] mode_q,
   output reg [15:0] sta_q,
   output reg [63:0] chan_res_q,
   output reg [71:0] ofs_q,
   output reg [47:0] gn_q,
   output reg mod_clk_q,
   output reg mod_rst_n_q,
   output reg [1:0] ch_pwr_q,
   output reg conv_irq_q,
   output reg wake_irq_q,
   output reg [31:0] acc_q,
   output wire res_vld,
   output wire [32:0] res_data
);
   localparam ST_PD = 2'd0;
   localparam ST_IDLE = 2'd1;
   localparam ST_CONV = 2'd2;
   localparam ST_CAL = 2'd3;

   reg [1:0] state_q;
   reg [2:0] settle_q;
   reg [1:0] got_q;
   reg [1:0] pend_q;
   reg fac_ld_q;
   reg [7:0] cnt_q;
   reg [8:0] div_q;
   reg [15:0] sta_d;
   integer i;

   wire [31:0] np_half = `SDM_NP_HALF;
   wire [31:0] lp_half = `SDM_LP_HALF;
   wire lp = mode_q[`SDM_MODE_LP_BIT];
   wire [2:0] code = mode_q[2:0];
   wire [1:0] on_m = ch_on & {~lp, 1'b1};
   wire cal = (state_q == ST_CAL);
   wire cont = (code == `SDM_MODE_CONT);
   wire gain_cal = (code == `SDM_MODE_SELF_GAIN) ||
                   (code == `SDM_MODE_SYS_FULL);
   // gain calibration is two stages, twice the offset duration
   wire [2:0] need = gain_cal ? (`SDM_SETTLE_OUTS + `SDM_SETTLE_OUTS)
                              : `SDM_SETTLE_OUTS;
   wire settled = (settle_q >= need);
   // a new mode write overrides whatever is running
   wire run = ((state_q == ST_CONV) || cal) && !mode_wr;
   wire ev = |(flt_vld & on_m);
   wire [1:0] take = {2{run && settled}} & flt_vld & on_m & ~pend_q &
                     (cont ? 2'b11 : ~got_q);
   wire [1:0] got_all = (got_q | take) & on_m;
   wire fifo_in_rdy;
   wire [1:0] pop_m = fifo_in_rdy ? (pend_q[0] ? 2'b01 : {pend_q[1], 1'b0})
                                  : 2'b00;
   wire [32:0] push_data = pend_q[0] ? {1'b0, chan_res_q[31:0]}
                                     : {1'b1, chan_res_q[63:32]};
   wire [63:0] corr_res;
   wire [63:0] cal_val;
   wire [1:0] corr_err;
   wire cur_take = take[0] && !cal;
   wire hit_thr = $signed(corr_res[23:0]) > $signed(thr);
   wire hit_cnt = ((cnt_q + 8'h01) == cnt_lim);

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_ch
         // voltage channel borrows the temperature set when sensing it
         wire [1:0] set = (g == 0) ? 2'd0 : (temp_sel ? 2'd2 : 2'd1);
         sdm_corr u_corr (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .raw(flt_data[g*24 +: 24]),
            .vld(flt_vld[g]),
            .chop(flt_chop),
            .ofs(ofs_q[set*24 +: 24]),
            .gn(gn_q[set*16 +: 16]),
            .unip(unip[g]),
            .ovr(flt_ovr[g]),
            .res(corr_res[g*32 +: 32]),
            .err(corr_err[g]),
            .cal_val(cal_val[g*32 +: 32])
         );
      end
   endgenerate

   sdm_fifo #(
      .W(33),
      .DEPTH(`SDM_FIFO_DEPTH),
      .AW(3)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .in_vld(|pend_q),
      .in_rdy(fifo_in_rdy),
      .in_data(push_data),
      .out_vld_q(res_vld),
      .out_rdy(res_rdy),
      .out_data_q(res_data)
   );

   function [1:0] st_of;
      input [2:0] c;
      begin
         case (c)
            `SDM_MODE_PD: st_of = ST_PD;
            `SDM_MODE_CONT: st_of = ST_CONV;
            `SDM_MODE_SINGLE: st_of = ST_CONV;
            `SDM_MODE_IDLE: st_of = ST_IDLE;
            default: st_of = ST_CAL;
         endcase
      end
   endfunction

   // flags: the clear goes first so a same-cycle event survives
   always @* begin
      sta_d = sta_q & ~sta_clr;
      for (i = 0; i < 2; i = i + 1) begin
         if (take[i]) begin
            sta_d[`SDM_STA_RDY0 + i] = 1'b1;
         end
         if (take[i] && !cal && corr_err[i]) begin
            sta_d[`SDM_STA_ERR0 + i] = 1'b1;
         end
      end
      if (cur_take && hit_thr) begin
         sta_d[`SDM_STA_THR] = 1'b1;
      end
      if (cur_take && hit_cnt) begin
         sta_d[`SDM_STA_CNT] = 1'b1;
      end
   end

   always @(posedge sys_clk) begin
      if (!rstn) begin
         mode_q <= `SDM_MODE_RST;
         state_q <= ST_IDLE;
         settle_q <= 3'h0;
         got_q <= 2'b00;
         pend_q <= 2'b00;
         fac_ld_q <= 1'b1;
         ofs_q <= 72'h0;
         gn_q <= 48'h0;
         chan_res_q <= 64'h0;
         sta_q <= 16'h0000;
         conv_irq_q <= 1'b0;
         wake_irq_q <= 1'b0;
         cnt_q <= 8'h00;
         acc_q <= 32'h00000000;
      end else begin
         if (fac_ld_q) begin
            fac_ld_q <= 1'b0;
            ofs_q <= fac_of;
            gn_q <= fac_gn;
         end else begin
            for (i = 0; i < 3; i = i + 1) begin
               if (coef_of_we[i]) begin
                  ofs_q[i*24 +: 24] <= coef_wdata;
               end
               if (coef_gn_we[i]) begin
                  gn_q[i*16 +: 16] <= coef_wdata[15:0];
               end
            end
         end

         if (mode_wr) begin
            mode_q <= mode_wdata;
            state_q <= st_of(mode_wdata[2:0]);
            settle_q <= 3'h0;
            got_q <= 2'b00;
         end else if (run) begin
            if (!settled && ev) begin
               settle_q <= settle_q + 3'h1;
            end
            got_q <= got_q | take;
            if (!cont && settled && (got_all == on_m)) begin
               state_q <= ST_IDLE;
               mode_q[2:0] <= `SDM_MODE_IDLE;
            end
         end

         for (i = 0; i < 2; i = i + 1) begin
            if (take[i]) begin
               // calibration leaves the coefficient registers alone
               chan_res_q[i*32 +: 32] <= cal ? cal_val[i*32 +: 32]
                                             : corr_res[i*32 +: 32];
            end
         end
         // a pending word blocks its channel, so a full FIFO stalls
         pend_q <= (pend_q & ~pop_m) | take;

         sta_q <= sta_d;
         conv_irq_q <= |(sta_d & irq_mask);
         wake_irq_q <= lp &&
            |(sta_d[`SDM_STA_CNT:`SDM_STA_THR] &
              irq_mask[`SDM_STA_CNT:`SDM_STA_THR]);

         if (cur_take) begin
            cnt_q <= hit_cnt ? 8'h00 : cnt_q + 8'h01;
         end
         if (acc_clr) begin
            acc_q <= 32'h00000000;
         end else if (cur_take) begin
            acc_q <= acc_q + {{8{corr_res[23]}}, corr_res[23:0]};
         end
      end
   end

   // modulator clock and analog controls
   always @(posedge sys_clk) begin
      if (!rstn) begin
         div_q <= 9'h000;
         mod_clk_q <= 1'b0;
         mod_rst_n_q <= 1'b0;
         ch_pwr_q <= 2'b00;
      end else begin
         if (state_q == ST_PD) begin
            div_q <= 9'h000;
            mod_clk_q <= 1'b0;
         end else if (div_q == (lp ? lp_half[8:0] - 9'h001
                                   : np_half[8:0] - 9'h001)) begin
            div_q <= 9'h000;
            mod_clk_q <= ~mod_clk_q;
         end else begin
            div_q <= div_q + 9'h001;
         end
         // idle keeps power on but holds the modulators in reset
         mod_rst_n_q <= run;
         ch_pwr_q <= (state_q == ST_PD) ? 2'b00 : on_m;
      end
   end
endmodule

// ==== verif/sdm_ctrl_asserts.sv ====
// port assertions for the mode and calibration control block
// assumes one sys_clk domain with a synchronous active low reset
`timescale 1ns/100ps
module sdm_ctrl_asserts (
   input wire sys_clk,
   input wire rstn,
   input wire mode_wr,
   input wire [3:0] mode_wdata,
   input wire [15:0] irq_mask,
   input wire [3:0] mode_q,
   input wire [15:0] sta_q,
   input wire [63:0] chan_res_q,
   input wire mod_clk_q,
   input wire mod_rst_n_q,
   input wire [1:0] ch_pwr_q,
   input wire conv_irq_q,
   input wire wake_irq_q
);
   reg [9:0] hc_q;
   reg ok_q;
   reg lp_q;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // a mode write may restart the divider, so that half is not judged
   always @(posedge sys_clk) begin
      if (!rstn || $changed(mod_clk_q)) begin
         hc_q <= 10'h000;
         ok_q <= rstn && (mode_q[2:0] != 3'h0) && !mode_wr;
         lp_q <= mode_q[3];
      end else begin
         hc_q <= hc_q + 10'h001;
         if (mode_wr)
            ok_q <= 1'b0;
      end
   end
   a_mode_write: assert property (
      mode_wr |=> mode_q == $past(mode_wdata)) else $error("mode write lost");
   a_lp_one_chan: assert property (
      mode_q[3] && $past(mode_q[3]) |-> !ch_pwr_q[1]) else $error("ch1 on");
   a_idle_held: assert property (
      mode_q[2:0] == 3'h3 && $past(mode_q[2:0]) == 3'h3 |-> !mod_rst_n_q)
      else $error("idle not in reset");
   a_mod_half: assert property (
      $changed(mod_clk_q) && ok_q |-> hc_q == (lp_q ? 10'h185 : 10'h060))
      else $error("modulator clock rate wrong");
   a_single_done: assert property (
      $past(mode_q[2:0]) == 3'h2 && mode_q[2:0] == 3'h3 && !$past(mode_wr)
      |-> sta_q[1:0] != 2'h0) else $error("idle without result");
   a_irq_follow: assert property (
      conv_irq_q == |(sta_q & $past(irq_mask))) else $error("irq mismatch");
   a_wake_lp_only: assert property (
      !mode_q[3] && !$past(mode_q[3]) |-> !wake_irq_q)
      else $error("wake in normal power");
   a_err_invalid: assert property (
      $rose(sta_q[12]) |-> chan_res_q[31]) else $error("error but valid");
   c_single: cover property ($past(mode_q[2:0]) == 3'h2 && mode_q == 4'h3);
   c_wake: cover property (wake_irq_q);
   c_lp_half: cover property ($changed(mod_clk_q) && ok_q && lp_q);
endmodule
bind sdm_ctrl sdm_ctrl_asserts chk (.*);

// ==== verif/sdm_mod_model.sv ====
// behavioural modulator plus decimation filter for both channels
// assumes the bench chooses the word values and overrange flags
`timescale 1ns/100ps
module sdm_mod_model #(
   parameter OSR = 4
) (
   input wire sys_clk,
   input wire mod_clk,
   input wire mod_rst_n,
   input wire [1:0] ch_pwr,
   input wire [47:0] word,
   input wire [1:0] ovr,
   output reg [47:0] flt_data = 48'h000000000000,
   output reg [1:0] flt_vld = 2'h0,
   output reg [1:0] flt_ovr = 2'h0
);
   reg clk_d = 1'b0;
   integer n = 0;
   // stale words are scrambled so nobody relies on a held value
   always @(posedge sys_clk) begin
      clk_d <= mod_clk;
      flt_vld <= 2'h0;
      flt_data <= ~flt_data;
      flt_ovr <= ~flt_ovr;
      if (!mod_rst_n)
         n <= 0;
      else if (mod_clk && !clk_d) begin
         if (n == OSR - 1) begin
            n <= 0;
            flt_vld <= ch_pwr;
            flt_data <= word;
            flt_ovr <= ovr;
         end else
            n <= n + 1;
      end
   end
endmodule

// ==== verif/test_sdm_ctrl.sv ====
// self-checking bench for the mode and calibration control block
// assumes the modulator model answers one word per powered channel
`timescale 1ns/100ps
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin \
failures = failures + 1; $display("[ERR] %0t %h %h", $time, a, b); end end
module test_sdm_ctrl;
   reg sys_clk = 1'b0;
   reg rstn = 1'b0;
   reg mode_wr = 1'b0;
   reg [3:0] mode_wdata = 4'h3;
   reg flt_chop = 1'b0;
   reg [1:0] ch_on = 2'h3;
   reg [1:0] unip = 2'h0;
   reg temp_sel = 1'b0;
   reg [2:0] coef_of_we = 3'h0;
   reg [2:0] coef_gn_we = 3'h0;
   reg [23:0] coef_wdata = 24'h000000;
   reg [71:0] fac_of = 72'h000003_000002_000010;
   reg [47:0] fac_gn = 48'h5555_5555_5555;
   reg [15:0] sta_clr = 16'h0000;
   reg [15:0] irq_mask = 16'h0000;
   reg [23:0] thr = 24'h7FFFFF;
   reg [7:0] cnt_lim = 8'h00;
   reg acc_clr = 1'b0;
   reg res_rdy = 1'b0;
   reg [47:0] word = 48'h000200_000100;
   reg [1:0] ovr = 2'h0;
   wire [47:0] flt_data;
   wire [1:0] flt_vld;
   wire [1:0] flt_ovr;
   wire [3:0] mode_q;
   wire [15:0] sta_q;
   wire [63:0] chan_res_q;
   wire [71:0] ofs_q;
   wire [47:0] gn_q;
   wire mod_clk_q;
   wire mod_rst_n_q;
   wire [1:0] ch_pwr_q;
   wire conv_irq_q;
   wire wake_irq_q;
   wire [31:0] acc_q;
   wire res_vld;
   wire [32:0] res_data;
   integer failures = 0;
   integer checks = 0;
   integer i;
   integer n;
   sdm_ctrl DUT (.*);
   sdm_mod_model PM (.sys_clk(sys_clk), .mod_clk(mod_clk_q),
      .mod_rst_n(mod_rst_n_q), .ch_pwr(ch_pwr_q), .word(word), .ovr(ovr),
      .flt_data(flt_data), .flt_vld(flt_vld), .flt_ovr(flt_ovr));
   always #5 sys_clk = ~sys_clk;
   task complete_run;
      begin
         $display("checks=%0d failures=%0d", checks, failures);
         if (failures == 0 && checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task set_mode(input [3:0] m);
      begin
         mode_wr = 1'b1;
         mode_wdata = m;
         @(negedge sys_clk);
         mode_wr = 1'b0;
      end
   endtask
   task coef(input [2:0] o, input [2:0] g, input [23:0] d);
      begin
         coef_of_we = o;
         coef_gn_we = g;
         coef_wdata = d;
         @(negedge sys_clk);
         coef_of_we = 3'h0;
         coef_gn_we = 3'h0;
         @(negedge sys_clk);
      end
   endtask
   task clr_sta;
      begin
         sta_clr = 16'hFFFF;
         @(negedge sys_clk);
         sta_clr = 16'h0000;
      end
   endtask
   // bounded so a stuck conversion ends as a mismatch, not a hang
   task wait_idle;
      begin
         i = 0;
         while (mode_q[2:0] !== 3'h3 && i < 40000) begin
            @(negedge sys_clk);
            i = i + 1;
         end
         if (i >= 40000)
            failures = failures + 1;
      end
   endtask
   task t_reset;
      begin
         `CHK(mode_q, 4'h3)
         `CHK(ofs_q[23:0], 24'h000010)
         `CHK(gn_q[15:0], 16'h5555)
         coef(3'h1, 3'h0, 24'hFFFFF0);
         coef(3'h0, 3'h1, 24'h004000);
         `CHK(ofs_q[23:0], 24'hFFFFF0)
      end
   endtask
   task t_lp;
      begin
         acc_clr = 1'b1;
         cnt_lim = 8'h01;
         thr = 24'h000050;
         irq_mask = 16'h0008;
         @(negedge sys_clk);
         acc_clr = 1'b0;
         set_mode(4'hA);
         wait_idle;
         `CHK(mode_q, 4'hB)
         `CHK(sta_q[1:0], 2'h1)
         `CHK(sta_q[3], 1'b1)
         `CHK(wake_irq_q, 1'b1)
         `CHK(acc_q, 32'h00000110)
         set_mode(4'h3);
         clr_sta;
         `CHK(wake_irq_q, 1'b0)
      end
   endtask
   task t_single;
      begin
         irq_mask = 16'h0001;
         coef(3'h2, 3'h0, 24'h000030);
         set_mode(4'h2);
         wait_idle;
         `CHK(chan_res_q[23:0], 24'h000110)
         `CHK(chan_res_q[55:32], 24'h00026A)
         `CHK(chan_res_q[31], 1'b0)
         `CHK(sta_q[1:0], 2'h3)
         `CHK(conv_irq_q, 1'b1)
         `CHK(mode_q, 4'h3)
         clr_sta;
         `CHK(conv_irq_q, 1'b0)
      end
   endtask
   task t_err;
      begin
         ch_on = 2'h1;
         ovr = 2'h1;
         set_mode(4'h2);
         wait_idle;
         `CHK(sta_q[12], 1'b1)
         `CHK(chan_res_q[31], 1'b1)
         `CHK(sta_q[1:0], 2'h1)
         ovr = 2'h0;
         ch_on = 2'h3;
         clr_sta;
      end
   endtask
   // results pile up with res_rdy low until the buffer refuses
   task t_cont;
      begin
         set_mode(4'h1);
         n = 0;
         for (i = 0; i < 20000 && n < 10; i = i + 1) begin
            @(negedge sys_clk);
            if (flt_vld[0] === 1'b1)
               n = n + 1;
         end
         `CHK(mode_q, 4'h1)
         `CHK(sta_q[1:0], 2'h3)
         set_mode(4'h3);
         res_rdy = 1'b1;
         n = 0;
         for (i = 0; i < 40; i = i + 1) begin
            if (res_vld === 1'b1 && n == 0)
               `CHK(res_data[32:0], 33'h000000110)
            if (res_vld === 1'b1)
               n = n + 1;
            @(negedge sys_clk);
         end
         `CHK(n, 32'h0000000B)
         `CHK(res_vld, 1'b0)
      end
   endtask
   task t_cal;
      begin
         for (n = 4; n < 7; n = n + 1) begin
            set_mode(4'h2);
            @(negedge sys_clk);
            set_mode(n[3:0]);
            wait_idle;
            `CHK(mode_q, 4'h3)
            `CHK(chan_res_q[31:0], 32'h00000100)
            `CHK(chan_res_q[63:32], 32'h00000200)
            `CHK(ofs_q[23:0], 24'hFFFFF0)
         end
      end
   endtask
   task t_pd;
      begin
         set_mode(4'h3);
         irq_mask = 16'h0000;
         ch_on = 2'h1;
         @(negedge sys_clk);
         ch_on = 2'h0;
         @(negedge sys_clk);
         set_mode(4'h0);
         repeat (4) @(negedge sys_clk);
         `CHK(ch_pwr_q, 2'h0)
         `CHK(mod_clk_q, 1'b0)
         `CHK(mod_rst_n_q, 1'b0)
         ch_on = 2'h2;
         @(negedge sys_clk);
         ch_on = 2'h3;
         @(negedge sys_clk);
         set_mode(4'h3);
         repeat (50000) @(negedge sys_clk);
         `CHK(ch_pwr_q, 2'h3)
      end
   endtask
   task t_temp;
      begin
         coef(3'h4, 3'h0, 24'h000020);
         coef(3'h0, 3'h4, 24'h004000);
         temp_sel = 1'b1;
         set_mode(4'h2);
         wait_idle;
         `CHK(chan_res_q[55:32], 24'h0001E0)
         temp_sel = 1'b0;
      end
   endtask
   initial begin
      repeat (2) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (2) @(negedge sys_clk);
      t_reset;
      t_lp;
      t_single;
      t_err;
      t_cont;
      t_pd;
      t_temp;
      t_cal;
      complete_run;
   end
   initial begin
      #990000;
      failures = failures + 1;
      complete_run;
   end
endmodule
